// >>> pim_pkg.sv
// Purpose: Shared constants for the program integrity monitor and its host end
// Assumes: 16-bit register words on a word-addressed control port
// Notes: Signature polynomial and seed are fixed here for both ends
package pim_pkg;
  // Register word addresses
  localparam logic [15:0] ADDR_CRC_REF_HIGH = 16'hE200;
  localparam logic [15:0] ADDR_CRC_REF_LOW = 16'hE201;
  localparam logic [15:0] ADDR_CRC_CHECK_EN = 16'hE202;
  localparam logic [15:0] ADDR_PC_LIMIT_EN = 16'hE210;
  localparam logic [15:0] ADDR_PC_LIMIT_HIGH = 16'hE211;
  localparam logic [15:0] ADDR_PC_LIMIT_LOW = 16'hE212;
  localparam logic [15:0] ADDR_NONMOD_START = 16'hE21F;
  localparam logic [15:0] ADDR_SIG_ERR = 16'hE225;
  localparam logic [15:0] ADDR_PC_ERR = 16'hE226;
  localparam logic [15:0] ADDR_AUTO_MUTE = 16'hE227;
  localparam logic [15:0] ADDR_PEAK_COUNT = 16'hE229;
  // Reset values and field positions
  localparam logic [13:0] NONMOD_RESET = 14'h1F00;
  localparam int MUTE_ON_SIG_BIT = 1;
  localparam int MUTE_ON_PC_BIT = 0;
  // Program memory and sequencing
  localparam int OP_W = 43;
  localparam int PROG_WORDS = 4096;
  localparam int PROG_AW = 12;
  localparam logic [15:0] PC_START = 16'h2010;
  localparam int CHECK_FRAMES = 4096;
  localparam logic [31:0] MAX_INSTR_NORMAL = 32'h00000E00;
  localparam logic [31:0] MAX_INSTR_DUAL = 32'h00000700;
  localparam logic [31:0] MAX_INSTR_QUAD = 32'h00000380;
  // Signature arithmetic
  localparam logic [31:0] SIG_POLY = 32'h04C11DB7;
  localparam logic [31:0] SIG_SEED = 32'hFFFFFFFF;
  // Multipurpose pin function codes
  localparam logic [1:0] MP_FUNC_NONE = 2'h0;
  localparam logic [1:0] MP_FUNC_SIG = 2'h1;
  localparam logic [1:0] MP_FUNC_PC = 2'h2;
endpackage : pim_pkg

// >>> pim_link_if.sv
// Purpose: Control port wires between host end and monitor end
// Assumes: Both ends share clk_in
// Notes: Request held until acknowledged
`timescale 1ns/1ps
interface pim_link_if;
  logic req; // Host request level
  logic wr; // High for write
  logic [15:0] addr; // Word address
  logic [15:0] wdata; // Write word
  logic ack; // One-cycle answer pulse
  logic [15:0] rdata; // Read word, valid with ack
  logic multipurpose_pin; // Fault level toward host
  modport dev (input req, wr, addr, wdata, output ack, rdata, multipurpose_pin);
  modport hst (output req, wr, addr, wdata, input ack, rdata, multipurpose_pin);
endinterface : pim_link_if

// >>> pim_monitor.sv
// Purpose: Program integrity monitor at the DSP core end
// Assumes: prog_data_in is the word at crc_addr_out in the same cycle
// Notes: Scan runs only while the core sequencer is idle
// How it works
// RL1: Reference signature split high word first
// RL2: Recompute signature every 4096 frames when enabled
// RL3: Mismatch sets read-only sticky signature error
// RL4: Signature error clears when check disabled
// RL5: Checking runs only while enable set
// RL6: Pin shows signature error when selected
// RL7: Host recovers: disable, reload, re-enable
// RL8: Flag error when count reaches limit
// RL9: Limit split high word first, resets zero
// RL10: Limit checking only while enable high
// RL11: Limit error sticky, cleared by disable
// RL12: Pin shows limit error when selected
// RL13: Auto-mute bits: 1 signature, 0 limit
// RL14: Halt or mute zeroes audio output
// RL15: Peak counter counts start to return
// RL16: Peak count refreshed on frame start
// RL17: Peak count unreliable after limit error
// RL18: 4096 words; per-rate instruction caps
// RL19: Program words are 43 bits
// RL20: Nonmodulo start register, resets 7936
// RL21: Host zeroes data memory before boot
// RL22: Counter restarts at start per frame
// RL23: Cycle counter cleared by frame start
`timescale 1ns/1ps
module pim_monitor
  import pim_pkg::*;
#(
  parameter int AUDIO_W = 24
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  pim_link_if.dev link,
  input wire logic frame_start_in,
  input wire logic pc_jump_in,
  input wire logic core_run_in,
  input wire logic [1:0] rate_sel_in,
  input wire logic [1:0] mp_func_in,
  input wire logic [OP_W-1:0] prog_data_in,
  input wire logic [AUDIO_W-1:0] audio_in,
  output logic [PROG_AW-1:0] crc_addr_out,
  output logic [15:0] pc_out,
  output logic pc_running_out,
  output logic [13:0] nonmod_start_out,
  output logic [AUDIO_W-1:0] audio_out,
  output logic mute_out,
  output logic overrun_out
);

  ////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [15:0] ref_hi; // Reference upper half
    logic [15:0] ref_lo; // Reference lower half
    logic sig_en; // Signature check enable
    logic lim_en; // Cycle limit enable
    logic [15:0] lim_hi; // Limit upper half
    logic [15:0] lim_lo; // Limit lower half
    logic [13:0] nonmod; // Nonmodulo start
    logic sig_err; // Sticky signature error
    logic lim_err; // Sticky limit error
    logic [1:0] auto_mute; // Auto-mute selects
    logic [15:0] peak; // Last frame cycle count
    logic ack; // Link answer
    logic [15:0] rdata; // Link read word
    logic [15:0] pc; // Program counter
    logic running; // Program executing
    logic [31:0] cyc; // Cycles since frame start
    logic overrun; // Over per-rate cap this frame
    logic [PROG_AW-1:0] frames; // Frames since last check
    logic scan_due; // Check pending
    logic scanning; // Scan in progress
    logic [PROG_AW-1:0] scan_addr; // Word under scan
    logic [31:0] sig; // Running signature
    logic mp; // Pin level
    logic mute; // Output mute
    logic [AUDIO_W-1:0] audio; // Gated sample
  } pim_mon_state_t;

  pim_mon_state_t st; // Registered state
  pim_mon_state_t next_st; // Next state

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // Fold one 43-bit program word into the signature, msb first
  function automatic logic [31:0] pim_fold(input logic [31:0] sig, input logic [OP_W-1:0] word);
    logic [31:0] s;
    logic fb;
    s = sig;
    for (int i = OP_W - 1; i >= 0; i--) begin
      fb = s[31] ^ word[i];
      s = {s[30:0], 1'b0} ^ (fb ? SIG_POLY : 32'h00000000);
    end
    return s;
  endfunction : pim_fold

  // Per-rate instruction cap
  function automatic logic [31:0] pim_cap(input logic [1:0] rate);
    case (rate)
      2'h1: return MAX_INSTR_DUAL;
      2'h2: return MAX_INSTR_QUAD;
      default: return MAX_INSTR_NORMAL;
    endcase
  endfunction : pim_cap

  ////////////////////////////////////////////////////////////////////
  // Next-state logic

  logic wr_take; // Write taken this cycle
  logic sig_set; // Mismatch event
  logic lim_set; // Limit reached event
  logic [31:0] folded; // Signature after this word

  always_comb begin
    next_st = st;
    wr_take = link.req && link.wr && !st.ack;
    folded = pim_fold(st.sig, prog_data_in);
    sig_set = 1'b0;
    lim_set = 1'b0;

    // Register writes; one request answered per ack pulse
    next_st.ack = link.req && !st.ack;
    if (wr_take) begin
      case (link.addr)
        ADDR_CRC_REF_HIGH: next_st.ref_hi = link.wdata; // RL1
        ADDR_CRC_REF_LOW: next_st.ref_lo = link.wdata; // RL1
        ADDR_CRC_CHECK_EN: next_st.sig_en = link.wdata[0]; // RL5
        ADDR_PC_LIMIT_EN: next_st.lim_en = link.wdata[0]; // RL10
        ADDR_PC_LIMIT_HIGH: next_st.lim_hi = link.wdata; // RL9
        ADDR_PC_LIMIT_LOW: next_st.lim_lo = link.wdata; // RL9
        ADDR_NONMOD_START: next_st.nonmod = link.wdata[13:0]; // RL20
        ADDR_AUTO_MUTE: next_st.auto_mute = link.wdata[1:0]; // RL13
        default: ; // Read-only or unmapped: ignored
      endcase
    end

    // Program counter sequencing
    if (frame_start_in) begin
      next_st.pc = PC_START; // RL22
      next_st.running = 1'b1;
      next_st.cyc = 32'h00000000; // RL23
      next_st.peak = st.cyc[15:0]; // RL15 RL16
      next_st.overrun = 1'b0;
    end else if (st.running) begin
      next_st.cyc = st.cyc + 32'h00000001; // RL23
      if (pc_jump_in) begin
        next_st.pc = PC_START; // RL22
        next_st.running = 1'b0;
      end else begin
        next_st.pc = st.pc + 16'h0001;
      end
      if (st.cyc >= pim_cap(rate_sel_in)) begin
        next_st.overrun = 1'b1; // RL18
      end
    end

    // Cycle limit watchdog; count before frame clear is compared
    lim_set = st.lim_en && st.running && (st.cyc == {st.lim_hi, st.lim_lo}); // RL8 RL10

    // Frame pacing for the periodic signature check
    if (!st.sig_en) begin
      next_st.frames = '0;
      next_st.scan_due = 1'b0;
      next_st.scanning = 1'b0;
    end else if (frame_start_in) begin
      next_st.frames = st.frames + 1'b1;
      if (st.frames == PROG_AW'(CHECK_FRAMES - 1)) begin
        next_st.scan_due = 1'b1; // RL2
      end
    end

    // Scan only between frames so it never races the core's fetch
    if (st.sig_en && st.scan_due && !st.scanning) begin
      next_st.scanning = 1'b1;
      next_st.scan_due = 1'b0;
      next_st.scan_addr = '0;
      next_st.sig = SIG_SEED;
    end else if (st.sig_en && st.scanning && !st.running && !frame_start_in) begin
      next_st.sig = folded; // RL19
      next_st.scan_addr = st.scan_addr + 1'b1;
      if (st.scan_addr == PROG_AW'(PROG_WORDS - 1)) begin
        next_st.scanning = 1'b0;
        sig_set = (folded != {st.ref_hi, st.ref_lo}); // RL2
      end
    end

    // Sticky flags: set beats the clear from a disabling write
    next_st.sig_err = sig_set || (st.sig_err && next_st.sig_en); // RL3 RL4
    next_st.lim_err = lim_set || (st.lim_err && next_st.lim_en); // RL11

    // Read answer from state as it stands at the take edge
    next_st.rdata = 16'h0000;
    if (link.req && !st.ack && !link.wr) begin
      case (link.addr)
        ADDR_CRC_REF_HIGH: next_st.rdata = st.ref_hi;
        ADDR_CRC_REF_LOW: next_st.rdata = st.ref_lo;
        ADDR_CRC_CHECK_EN: next_st.rdata = {15'h0000, st.sig_en};
        ADDR_PC_LIMIT_EN: next_st.rdata = {15'h0000, st.lim_en};
        ADDR_PC_LIMIT_HIGH: next_st.rdata = st.lim_hi;
        ADDR_PC_LIMIT_LOW: next_st.rdata = st.lim_lo;
        ADDR_NONMOD_START: next_st.rdata = {2'h0, st.nonmod};
        ADDR_SIG_ERR: next_st.rdata = {15'h0000, st.sig_err}; // RL3
        ADDR_PC_ERR: next_st.rdata = {15'h0000, st.lim_err}; // RL11
        ADDR_AUTO_MUTE: next_st.rdata = {14'h0000, st.auto_mute};
        ADDR_PEAK_COUNT: next_st.rdata = st.peak; // RL15
        default: next_st.rdata = 16'h0000;
      endcase
    end

    // Pin follows the selected sticky flag
    case (mp_func_in)
      MP_FUNC_SIG: next_st.mp = st.sig_err; // RL6
      MP_FUNC_PC: next_st.mp = st.lim_err; // RL12
      default: next_st.mp = 1'b0;
    endcase

    // Mute is abrupt, so a click is the price of no residual dc
    next_st.mute = !core_run_in
      || (st.auto_mute[MUTE_ON_SIG_BIT] && st.sig_err)
      || (st.auto_mute[MUTE_ON_PC_BIT] && st.lim_err); // RL13
    next_st.audio = next_st.mute ? '0 : audio_in; // RL14
  end

  ////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st <= '0;
      st.nonmod <= NONMOD_RESET; // RL20
      st.pc <= PC_START;
      st.sig <= SIG_SEED;
      st.mute <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  assign link.ack = st.ack;
  assign link.rdata = st.rdata;
  assign link.multipurpose_pin = st.mp;
  assign crc_addr_out = st.scan_addr;
  assign pc_out = st.pc;
  assign pc_running_out = st.running;
  assign nonmod_start_out = st.nonmod;
  assign audio_out = st.audio;
  assign mute_out = st.mute;
  assign overrun_out = st.overrun;

endmodule : pim_monitor

// >>> pim_host.sv
// Purpose: Host controller end of the integrity monitor control port
// Assumes: One command at a time from the user side
// Notes: Wide writes go high word first; recovery waits on reload_done_in
`timescale 1ns/1ps
module pim_host
  import pim_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  pim_link_if.hst link,
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic cmd_wide_in,
  input wire logic cmd_recover_in,
  input wire logic [15:0] cmd_addr_in,
  input wire logic [31:0] cmd_wdata_in,
  input wire logic reload_done_in,
  output logic cmd_ready_out,
  output logic resp_valid_out,
  output logic [15:0] resp_data_out,
  output logic reload_req_out,
  output logic fault_out
);

  ////////////////////////////////////////////////////////////////////
  // State

  typedef enum logic [1:0] {
    PIM_H_IDLE = 2'b00, // Ready for a command
    PIM_H_WAIT = 2'b01, // Request out, awaiting ack
    PIM_H_RELOAD = 2'b10 // Waiting for program reload
  } pim_host_fsm_t;

  typedef struct packed {
    pim_host_fsm_t fsm; // Sequencer state
    logic req; // Link request
    logic wr; // Link write
    logic [15:0] addr; // Link address
    logic [15:0] wdata; // Link data
    logic [15:0] lo_word; // Second word of a wide write
    logic second; // Wide write second half pending
    logic recover; // Recovery sequence active
    logic resp_valid; // Answer pulse
    logic [15:0] resp_data; // Answer word
    logic reload_req; // Reload request level
    logic fault; // Synchronous pin copy
    logic ready; // Idle, free for a command
  } pim_host_state_t;

  pim_host_state_t st; // Registered state
  pim_host_state_t next_st; // Next state

  ////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    next_st = st;
    next_st.resp_valid = 1'b0;
    next_st.fault = link.multipurpose_pin;
    unique case (st.fsm)
      PIM_H_IDLE: begin
        if (cmd_valid_in && cmd_recover_in) begin
          next_st.recover = 1'b1; // RL7
          next_st.req = 1'b1;
          next_st.wr = 1'b1;
          next_st.addr = ADDR_CRC_CHECK_EN;
          next_st.wdata = 16'h0000;
          next_st.fsm = PIM_H_WAIT;
        end else if (cmd_valid_in) begin
          next_st.req = 1'b1;
          next_st.wr = cmd_write_in || cmd_wide_in;
          next_st.addr = cmd_addr_in;
          // Upper half goes to the lower address
          next_st.wdata = cmd_wide_in ? cmd_wdata_in[31:16] : cmd_wdata_in[15:0]; // RL1 RL9
          next_st.lo_word = cmd_wdata_in[15:0];
          next_st.second = cmd_wide_in;
          next_st.fsm = PIM_H_WAIT;
        end
      end
      PIM_H_WAIT: begin
        if (link.ack) begin
          next_st.req = 1'b0;
          if (st.second) begin
            next_st.second = 1'b0;
            next_st.req = 1'b1;
            next_st.addr = st.addr + 16'h0001; // RL1 RL9
            next_st.wdata = st.lo_word;
          end else if (st.recover && st.wdata == 16'h0000) begin
            next_st.reload_req = 1'b1; // RL7
            next_st.fsm = PIM_H_RELOAD;
          end else begin
            next_st.recover = 1'b0;
            next_st.resp_valid = 1'b1;
            next_st.resp_data = link.rdata;
            next_st.fsm = PIM_H_IDLE;
          end
        end
      end
      PIM_H_RELOAD: begin
        // Reload is expected to zero data memory as well before re-enable
        if (reload_done_in) begin
          next_st.reload_req = 1'b0;
          next_st.req = 1'b1;
          next_st.addr = ADDR_CRC_CHECK_EN;
          next_st.wdata = 16'h0001; // RL5 RL7 RL21
          next_st.fsm = PIM_H_WAIT;
        end
      end
      default: next_st.fsm = PIM_H_IDLE;
    endcase
    // Ready registered so the user side sees a flop, not a compare
    next_st.ready = (next_st.fsm == PIM_H_IDLE);
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  assign link.req = st.req;
  assign link.wr = st.wr;
  assign link.addr = st.addr;
  assign link.wdata = st.wdata;
  assign cmd_ready_out = st.ready;
  assign resp_valid_out = st.resp_valid;
  assign resp_data_out = st.resp_data;
  assign reload_req_out = st.reload_req;
  assign fault_out = st.fault;

endmodule : pim_host

// >>> pim_link_asserts.sv
// Purpose: Protocol and register checks on the link between the two ends
// Assumes: Plain copies of the pim_link_if signals, one clock domain
// Notes: No bind; the bench instantiates this beside the interface
`timescale 1ns/1ps
module pim_link_asserts
  import pim_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic req,
  input wire logic wr,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic ack,
  input wire logic [15:0] rdata
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic sig_off; // Check enable last written low
  logic lim_off; // Limit enable last written low
  logic rd; // Read answered this cycle
  assign rd = ack && !wr;
  ////////////////////////////////////////////////////////////////
  // Shadow the enables from acked writes; both are off after reset
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sig_off <= 1'b1;
      lim_off <= 1'b1;
    end else if (ack && wr) begin
      if (addr == ADDR_CRC_CHECK_EN) sig_off <= !wdata[0];
      if (addr == ADDR_PC_LIMIT_EN) lim_off <= !wdata[0];
    end
  end
  ////////////////////////////////////////////////////////////////
  ack_one_cycle_a: assert property (ack |=> !ack) else $error("ack longer than one cycle");
  ack_answers_req_a: assert property (req && !ack |=> ack) else $error("request not answered");
  req_held_a: assert property (
    req && !ack |=> req && $stable(addr) && $stable(wr) && $stable(wdata))
    else $error("request changed before ack");
  // A wide write may keep req up, but only to move on to the next word
  req_released_a: assert property (
    ack |=> !req || (wr && addr == $past(addr) + 16'h0001))
    else $error("request kept after ack");
  wide_pairing_a: assert property (
    ack && wr && addr == ADDR_CRC_REF_HIGH |-> ##[2:3] (req && wr && addr == ADDR_CRC_REF_LOW))
    else $error("low half not sent after high half");
  write_rdata_a: assert property (ack && wr |-> rdata == 16'h0000) else $error("write gave data");
  sig_flag_a: assert property (
    rd && addr == ADDR_SIG_ERR |-> rdata[15:1] == 15'h0000 && !(sig_off && rdata[0]))
    else $error("signature flag wrong");
  lim_flag_a: assert property (
    rd && addr == ADDR_PC_ERR |-> rdata[15:1] == 15'h0000 && !(lim_off && rdata[0]))
    else $error("limit flag wrong");
  mute_width_a: assert property (
    rd && addr == ADDR_AUTO_MUTE |-> rdata[15:2] == 14'h0000)
    else $error("mute register too wide");
  nonmod_width_a: assert property (
    rd && addr == ADDR_NONMOD_START |-> rdata[15:14] == 2'h0)
    else $error("boundary register too wide");
  unmapped_zero_a: assert property (
    rd && addr == 16'hE203 |-> rdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule : pim_link_asserts

// >>> program_integrity_monitor_tb.sv
// Purpose: Bench for the monitor and host ends joined by the link
// Assumes: Host user side and core side driven on falling edges
// Notes: Signature reference left wrong on purpose to force a mismatch
`timescale 1ns/1ps
module program_integrity_monitor_tb;
  import pim_pkg::*;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic cmd_valid_in = 1'b0, cmd_write_in = 1'b0, cmd_wide_in = 1'b0, cmd_recover_in = 1'b0;
  logic [15:0] cmd_addr_in = 16'h0000;
  logic [31:0] cmd_wdata_in = 32'h00000000;
  logic reload_done_in = 1'b0, frame_start_in = 1'b0, pc_jump_in = 1'b0, core_run_in = 1'b1;
  logic [1:0] rate_sel_in = 2'h0, mp_func_in = 2'h0;
  logic [23:0] audio_in = 24'h000000, audio_out;
  logic [42:0] prog_data_in; // Program memory stand-in
  logic [11:0] crc_addr_out;
  logic [15:0] pc_out, resp_data_out, pc_seen, r;
  logic [13:0] nonmod_start_out;
  logic pc_running_out, mute_out, overrun_out, cmd_ready_out, resp_valid_out, reload_req_out, fault_out, ovr_seen;
  int fail_count = 0, samples_checked = 0;
  int caps [4] = '{3584, 1792, 896, 3584}; // Per-rate caps; code 3 is normal
  logic [15:0] ra [11] = '{ADDR_CRC_REF_HIGH, ADDR_CRC_REF_LOW, ADDR_CRC_CHECK_EN, ADDR_PC_LIMIT_EN,
    ADDR_PC_LIMIT_HIGH, ADDR_PC_LIMIT_LOW, ADDR_NONMOD_START, ADDR_SIG_ERR, ADDR_PC_ERR, ADDR_AUTO_MUTE, 16'hE203};
  // Word content follows the scan address so the signature is never trivial
  assign prog_data_in = {31'h0, crc_addr_out};
  pim_link_if link_if ();
  pim_monitor pim_monitor_inst (.clk_in(clk_in), .nrst_in(nrst_in), .link(link_if), .frame_start_in(frame_start_in),
    .pc_jump_in(pc_jump_in), .core_run_in(core_run_in), .rate_sel_in(rate_sel_in), .mp_func_in(mp_func_in),
    .prog_data_in(prog_data_in), .audio_in(audio_in), .crc_addr_out(crc_addr_out), .pc_out(pc_out),
    .pc_running_out(pc_running_out), .nonmod_start_out(nonmod_start_out), .audio_out(audio_out),
    .mute_out(mute_out), .overrun_out(overrun_out));
  pim_host pim_host_inst (.clk_in(clk_in), .nrst_in(nrst_in), .link(link_if), .cmd_valid_in(cmd_valid_in),
    .cmd_write_in(cmd_write_in), .cmd_wide_in(cmd_wide_in), .cmd_recover_in(cmd_recover_in),
    .cmd_addr_in(cmd_addr_in), .cmd_wdata_in(cmd_wdata_in), .reload_done_in(reload_done_in),
    .cmd_ready_out(cmd_ready_out), .resp_valid_out(resp_valid_out), .resp_data_out(resp_data_out),
    .reload_req_out(reload_req_out), .fault_out(fault_out));
  pim_link_asserts pim_link_asserts_inst (.clk_in(clk_in), .nrst_in(nrst_in), .req(link_if.req), .wr(link_if.wr),
    .addr(link_if.addr), .wdata(link_if.wdata), .ack(link_if.ack), .rdata(link_if.rdata));
  ////////////////////////////////////////////////////////////////
  // Free-running 200 MHz clock
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One host command; answers a reload request at once
  task automatic cmd(input logic w, input logic wide, input logic rec, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    while (cmd_ready_out !== 1'b1 && n < 50) begin
      @(negedge clk_in);
      n++;
    end
    {cmd_valid_in, cmd_write_in, cmd_wide_in, cmd_recover_in, cmd_addr_in, cmd_wdata_in} = {1'b1, w, wide, rec, a, d};
    @(negedge clk_in);
    cmd_valid_in = 1'b0;
    cmd_recover_in = 1'b0;
    n = 0;
    while (resp_valid_out !== 1'b1 && n < 2000) begin
      reload_done_in = reload_req_out; // Reload finishes promptly
      @(negedge clk_in);
      n++;
    end
    reload_done_in = 1'b0;
    r = resp_data_out;
    if (n >= 2000) check(32'h0, 32'h1);
  endtask : cmd
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    cmd(1'b0, 1'b0, 1'b0, a, 32'h0);
    check(r, exp);
  endtask : rd
  // Frame of n cycles; samples pc and overrun just before the jump
  task automatic frame(input int n);
    frame_start_in = 1'b1;
    @(negedge clk_in);
    frame_start_in = 1'b0;
    repeat (n - 1) @(negedge clk_in);
    pc_seen = pc_out;
    ovr_seen = overrun_out;
    pc_jump_in = 1'b1;
    @(negedge clk_in);
    pc_jump_in = 1'b0;
  endtask : frame
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////
  // Watchdog sized well past the expected run length
  initial begin
    #450000;
    fail_count++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    @(negedge clk_in);
    check(pc_out, PC_START);
    check(nonmod_start_out, NONMOD_RESET);
    check(mute_out, 1'b1);
    repeat (20) @(negedge clk_in);
    nrst_in = 1'b1;
    @(negedge clk_in);
    foreach (ra[i]) rd(ra[i], (ra[i] == ADDR_NONMOD_START) ? 16'h1F00 : 16'h0000);
    $display("Test reset values done");
    cmd(1'b1, 1'b1, 1'b0, ADDR_CRC_REF_HIGH, 32'h1234ABCD);
    rd(ADDR_CRC_REF_HIGH, 16'h1234);
    rd(ADDR_CRC_REF_LOW, 16'hABCD);
    cmd(1'b1, 1'b0, 1'b0, ADDR_SIG_ERR, 32'h1);
    rd(ADDR_SIG_ERR, 16'h0000);
    cmd(1'b1, 1'b0, 1'b0, ADDR_NONMOD_START, 32'h0ABC);
    rd(ADDR_NONMOD_START, 16'h0ABC);
    check(nonmod_start_out, 14'h0ABC);
    audio_in = 24'h5A5A5A;
    repeat (2) @(negedge clk_in);
    check(audio_out, 24'h5A5A5A);
    core_run_in = 1'b0;
    repeat (2) @(negedge clk_in);
    check({mute_out, audio_out}, 25'h1000000);
    core_run_in = 1'b1;
    $display("Test registers and audio done");
    frame(4);
    check(pc_seen, PC_START + 16'h3);
    check({pc_running_out, pc_out}, {1'b0, PC_START});
    frame(2);
    rd(ADDR_PEAK_COUNT, 16'h0004);
    foreach (caps[k]) begin
      rate_sel_in = 2'(k);
      frame(caps[k] - 2);
      check(ovr_seen, 1'b0);
      frame(caps[k] + 2);
      check(ovr_seen, 1'b1);
    end
    rd(ADDR_PC_ERR, 16'h0000);
    $display("Test frames and rates done");
    mp_func_in = MP_FUNC_PC;
    cmd(1'b1, 1'b1, 1'b0, ADDR_PC_LIMIT_HIGH, 32'h0000000A);
    cmd(1'b1, 1'b0, 1'b0, ADDR_AUTO_MUTE, 32'h1);
    cmd(1'b1, 1'b0, 1'b0, ADDR_PC_LIMIT_EN, 32'h1);
    frame(10);
    rd(ADDR_PC_ERR, 16'h0000);
    check(mute_out, 1'b0);
    cmd(1'b1, 1'b1, 1'b0, ADDR_PC_LIMIT_HIGH, 32'h00000009);
    frame(10);
    rd(ADDR_PC_ERR, 16'h0001);
    check({link_if.multipurpose_pin, fault_out}, 2'h3);
    mp_func_in = MP_FUNC_NONE;
    repeat (2) @(negedge clk_in);
    check(link_if.multipurpose_pin, 1'b0);
    check({mute_out, audio_out}, 25'h1000000);
    cmd(1'b1, 1'b0, 1'b0, ADDR_PC_LIMIT_EN, 32'h0);
    rd(ADDR_PC_ERR, 16'h0000);
    check(mute_out, 1'b0);
    $display("Test limit done");
    mp_func_in = MP_FUNC_SIG;
    cmd(1'b1, 1'b0, 1'b0, ADDR_AUTO_MUTE, 32'h2);
    cmd(1'b1, 1'b1, 1'b0, ADDR_CRC_REF_HIGH, 32'h0);
    cmd(1'b1, 1'b0, 1'b0, ADDR_CRC_CHECK_EN, 32'h1);
    repeat (4095) frame(2);
    rd(ADDR_SIG_ERR, 16'h0000);
    frame(2);
    repeat (2048) @(negedge clk_in);
    check(crc_addr_out, 12'h800);
    repeat (2152) @(negedge clk_in);
    rd(ADDR_SIG_ERR, 16'h0001);
    check({link_if.multipurpose_pin, mute_out}, 2'h3);
    cmd(1'b0, 1'b0, 1'b1, 16'h0000, 32'h0);
    rd(ADDR_SIG_ERR, 16'h0000);
    rd(ADDR_CRC_CHECK_EN, 16'h0001);
    $display("Test signature done");
    report_and_stop();
  end
endmodule : program_integrity_monitor_tb
